// ===== logic/sdmc_pkg.sv
package sdmc_pkg;
    // clock
    localparam int CLK_PERIOD_PS = 20000;
    // device timing, picoseconds except mode set delay in cycles
    localparam int T_CAC_MIN_PS = 15000;
    localparam int T_RC_PS = 63000;
    localparam int T_RP_PS = 21000;
    localparam int T_XSR_PS = 70000;
    localparam int T_PDE_PS = 7000;
    localparam int T_MRD_CYC = 2;
    // refresh budget
    localparam int REF_COUNT = 4096;
    localparam int REF_PERIOD_MS = 64;
    localparam longint REF_INTERVAL_PS = longint'(REF_PERIOD_MS) * 64'd1000000000 / REF_COUNT;
    // cycle counts: least times round up, at least one
    localparam int RC_CYC = (T_RC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int RP_CYC = (T_RP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int XSR_CYC = (T_XSR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PDE_CYC = (T_PDE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // longest times round down, latency rounds up
    localparam int REF_INT_CYC = int'(REF_INTERVAL_PS / CLK_PERIOD_PS);
    localparam int PD_MAX_CYC = int'(longint'(REF_PERIOD_MS) * 64'd1000000000 / CLK_PERIOD_PS);
    localparam int CL_CYC = (T_CAC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // mode register field positions and codes
    localparam int MR_BL_POS = 0;
    localparam int MR_BT_POS = 3;
    localparam int MR_CL_POS = 4;
    localparam int MR_TM_POS = 7;
    localparam int MR_WB_POS = 9;
    localparam logic [2:0] CL_CODE_2 = 3'h2;
    localparam logic [2:0] CL_CODE_3 = 3'h3;
    localparam logic [1:0] TM_NORMAL = 2'h0;
    localparam logic [11:0] MODE_RESET = 12'h000;
    localparam logic [11:0] MODE_KEEP = 12'h3FF;
    localparam int TIMER_W = 24;
    localparam int REFCNT_W = 13;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_DESEL = 4'hF;
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_BSTOP = 4'h6;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
endpackage : sdmc_pkg

// ===== logic/sdmc_ctrl.sv
// Behaviour
// - program smallest latency covering column access time
// - test mode bits always written 00
// - A10, BA0, BA1 low during mode set
// - idle and wait cycles issue no-operation
// - 4096 auto refreshes every 64 ms
// - refresh only idle and CKE previously high
// - no-operations for row cycle, then precharge time
// - self refresh holds CKE low throughout
// - restart clock, then raise CKE to exit
// - no-operations for exit time after self refresh
// - refresh burst around self refresh recommended
// - power-down never exceeds 64 ms refresh period
// - power-down exit waits exit time plus one
// - mode set waits two cycles before next
module sdmc_ctrl #(
    parameter int REF_INT = sdmc_pkg::REF_INT_CYC,
    parameter int PD_MAX = sdmc_pkg::PD_MAX_CYC
) (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // user requests as one-cycle pulses, with mode value and data mask as levels
    input wire logic i_mode_req,
    input wire logic [11:0] i_mode_val,
    input wire logic i_bstop_req,
    input wire logic i_sr_enter_req,
    input wire logic i_sr_exit_req,
    input wire logic i_pd_enter_req,
    input wire logic i_pd_exit_req,
    input wire logic i_mask,
    // user status
    output logic o_busy,
    output logic o_in_self_refresh,
    output logic o_in_power_down,
    output logic [12:0] o_ref_total,
    // device pins
    output logic O_SD_CLK_EN,
    output logic O_SD_CKE,
    output logic O_SD_CS_N,
    output logic O_SD_RAS_N,
    output logic O_SD_CAS_N,
    output logic O_SD_WE_N,
    output logic [11:0] O_SD_ADDR,
    output logic [1:0] O_SD_BA,
    output logic O_SD_DQM
);
    // idle first so an all-zero state reads as idle
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_MRD,
        ST_REF_RC,
        ST_REF_RP,
        ST_SR_BURST,
        ST_SR_IN,
        ST_SR_CKE,
        ST_SR_XSR,
        ST_SR_POST,
        ST_PD,
        ST_PD_EXIT
    } sdmc_state_t;

    // all state in one record, next value built combinationally
    typedef struct packed {
        sdmc_state_t st;
        logic [sdmc_pkg::TIMER_W-1:0] wait_cnt;
        logic [sdmc_pkg::TIMER_W-1:0] ref_tmr;
        logic [sdmc_pkg::TIMER_W-1:0] pd_tmr;
        logic [sdmc_pkg::REFCNT_W-1:0] burst_cnt;
        logic [sdmc_pkg::REFCNT_W-1:0] ref_total;
        logic ref_due;
        logic exit_pend;
        logic clk_en;
        logic cke;
        logic cke_prev;
        logic [3:0] cmd;
        logic [11:0] addr;
        logic dqm;
    } sdmc_regs_t;

    // wait lengths sized to the shared counter
    localparam logic [sdmc_pkg::TIMER_W-1:0] RC_W = sdmc_pkg::TIMER_W'(sdmc_pkg::RC_CYC);
    localparam logic [sdmc_pkg::TIMER_W-1:0] RP_W = sdmc_pkg::TIMER_W'(sdmc_pkg::RP_CYC);
    localparam logic [sdmc_pkg::TIMER_W-1:0] XSR_W = sdmc_pkg::TIMER_W'(sdmc_pkg::XSR_CYC);
    localparam logic [sdmc_pkg::TIMER_W-1:0] PDE_W = sdmc_pkg::TIMER_W'(sdmc_pkg::PDE_CYC);
    localparam logic [sdmc_pkg::TIMER_W-1:0] MRD_W = sdmc_pkg::TIMER_W'(sdmc_pkg::T_MRD_CYC);
    localparam logic [sdmc_pkg::TIMER_W-1:0] REF_W = sdmc_pkg::TIMER_W'(REF_INT);
    localparam logic [sdmc_pkg::TIMER_W-1:0] PDMAX_W = sdmc_pkg::TIMER_W'(PD_MAX);
    localparam logic [sdmc_pkg::REFCNT_W-1:0] BURST_N = sdmc_pkg::REFCNT_W'(sdmc_pkg::REF_COUNT);
    localparam logic [2:0] CL_SEL = (sdmc_pkg::CL_CYC <= 2) ? sdmc_pkg::CL_CODE_2 : sdmc_pkg::CL_CODE_3;

    // pins leave reset selected with a no-operation and the clock running
    localparam sdmc_regs_t RESET_REGS = '{
        st: ST_IDLE,
        wait_cnt: '0,
        ref_tmr: '0,
        pd_tmr: '0,
        burst_cnt: '0,
        ref_total: '0,
        ref_due: 1'b0,
        exit_pend: 1'b0,
        clk_en: 1'b1,
        cke: 1'b1,
        cke_prev: 1'b1,
        cmd: sdmc_pkg::CMD_NOP,
        addr: sdmc_pkg::MODE_RESET,
        dqm: 1'b0
    };

    // r is the registered state, n its next value
    sdmc_regs_t r;
    sdmc_regs_t n;

    // mode word with latency forced, test bits zero, upper bits zero
    function automatic logic [11:0] sdmc_mode_word(input logic [11:0] v);
        logic [11:0] m;
        m = v & sdmc_pkg::MODE_KEEP;
        m[sdmc_pkg::MR_CL_POS +: 3] = CL_SEL;
        m[sdmc_pkg::MR_TM_POS +: 2] = sdmc_pkg::TM_NORMAL;
        return m;
    endfunction : sdmc_mode_word

    always_comb begin
        n = r;
        n.cmd = sdmc_pkg::CMD_NOP;
        n.addr = '0;
        n.dqm = i_mask;
        n.cke_prev = r.cke;

        // shared wait counter for every timed gap
        if (r.wait_cnt != '0) begin
            n.wait_cnt = r.wait_cnt - 1'b1;
        end

        // refresh interval timer, frozen while the device refreshes itself
        if (r.ref_tmr >= REF_W - 1'b1) begin
            n.ref_tmr = '0;
            n.ref_due = 1'b1;
        end else if (r.st != ST_SR_IN) begin
            n.ref_tmr = r.ref_tmr + 1'b1;
        end

        // exit request is held, but one that arrives before self refresh is entered is cleared on entry
        if (i_sr_exit_req) begin
            n.exit_pend = 1'b1;
        end

        case (r.st)
            ST_IDLE: begin
                // burst stop first: it must land inside a running burst
                if (i_bstop_req) begin
                    n.cmd = sdmc_pkg::CMD_BSTOP;
                end else if (r.wait_cnt != '0) begin
                    n.cmd = sdmc_pkg::CMD_NOP;
                end else if (r.ref_due && r.cke && r.cke_prev) begin
                    n.cmd = sdmc_pkg::CMD_REF;
                    n.ref_due = 1'b0;
                    n.ref_total = r.ref_total + 1'b1;
                    n.wait_cnt = RC_W - 1'b1;
                    n.st = ST_REF_RC;
                end else if (i_mode_req) begin
                    n.cmd = sdmc_pkg::CMD_MRS;
                    n.addr = sdmc_mode_word(i_mode_val);
                    n.wait_cnt = MRD_W - 1'b1;
                    n.st = ST_MRD;
                end else if (i_sr_enter_req) begin
                    n.burst_cnt = BURST_N;
                    n.st = ST_SR_BURST;
                end else if (i_pd_enter_req) begin
                    n.cke = 1'b0;
                    n.pd_tmr = '0;
                    n.st = ST_PD;
                end
            end

            ST_MRD: begin
                if (r.wait_cnt == '0) begin
                    n.st = ST_IDLE;
                end
            end

            ST_REF_RC: begin
                if (r.wait_cnt == '0) begin
                    n.wait_cnt = RP_W - 1'b1;
                    n.st = ST_REF_RP;
                end
            end

            ST_REF_RP: begin
                if (r.wait_cnt == '0) begin
                    n.st = ST_IDLE;
                end
            end

            // one refresh per row cycle plus precharge time
            ST_SR_BURST, ST_SR_POST: begin
                if (r.wait_cnt == '0) begin
                    if (r.burst_cnt != '0) begin
                        n.cmd = sdmc_pkg::CMD_REF;
                        n.burst_cnt = r.burst_cnt - 1'b1;
                        n.ref_total = r.ref_total + 1'b1;
                        n.wait_cnt = RC_W + RP_W - 1'b1;
                    end else if (r.st == ST_SR_BURST) begin
                        n.cmd = sdmc_pkg::CMD_REF;
                        n.cke = 1'b0;
                        n.exit_pend = 1'b0;
                        n.st = ST_SR_IN;
                    end else begin
                        n.ref_due = 1'b0;
                        n.ref_tmr = '0;
                        n.st = ST_IDLE;
                    end
                end
            end

            // clock stopped and command inputs ignored while self refreshing
            ST_SR_IN: begin
                n.cmd = sdmc_pkg::CMD_DESEL;
                n.clk_en = 1'b0;
                if (r.exit_pend) begin
                    n.clk_en = 1'b1;
                    n.exit_pend = 1'b0;
                    n.st = ST_SR_CKE;
                end
            end

            ST_SR_CKE: begin
                n.cmd = sdmc_pkg::CMD_DESEL;
                n.cke = 1'b1;
                n.wait_cnt = XSR_W;
                n.st = ST_SR_XSR;
            end

            ST_SR_XSR: begin
                if (r.wait_cnt == '0) begin
                    n.burst_cnt = BURST_N;
                    n.st = ST_SR_POST;
                end
            end

            // leave on request, once a refresh falls due, or when the stay limit runs out
            ST_PD: begin
                n.cmd = sdmc_pkg::CMD_DESEL;
                n.pd_tmr = r.pd_tmr + 1'b1;
                if (i_pd_exit_req || r.ref_due || r.pd_tmr >= PDMAX_W - 1'b1) begin
                    n.cke = 1'b1;
                    n.wait_cnt = PDE_W;
                    n.st = ST_PD_EXIT;
                end
            end

            // one spare cycle after the exit time before the next command
            ST_PD_EXIT: begin
                if (r.wait_cnt == '0) begin
                    n.st = ST_IDLE;
                end
            end

            default: begin
                n.st = ST_IDLE;
            end
        endcase

        // exit request also collected while parked in self refresh
        if (r.st == ST_SR_IN) begin
            n.exit_pend = r.exit_pend | i_sr_exit_req;
        end
    end

    // asynchronous reset loads constants only
    always_ff @(posedge I_CLOCK or posedge I_RST) begin
        if (I_RST) begin
            r <= RESET_REGS;
        end else begin
            r <= n;
        end
    end

    // user status
    assign o_busy = (r.st != ST_IDLE) || (r.wait_cnt != '0);
    assign o_in_self_refresh = (r.st == ST_SR_IN);
    assign o_in_power_down = (r.st == ST_PD);
    assign o_ref_total = r.ref_total;

    // device pins
    assign O_SD_CLK_EN = r.clk_en;
    assign O_SD_CKE = r.cke;
    assign {O_SD_CS_N, O_SD_RAS_N, O_SD_CAS_N, O_SD_WE_N} = r.cmd;
    assign O_SD_ADDR = r.addr;
    // bank address is never used by these commands
    assign O_SD_BA = 2'h0;
    assign O_SD_DQM = r.dqm;
endmodule : sdmc_ctrl

// ===== verif/sdmc_ctrl_sva.sv
module sdmc_ctrl_sva #(
    parameter int REF_INT = 781,
    parameter int PD_MAX = 3200000
) (
    // clock and reset
    input wire logic I_CLOCK,
    input wire logic I_RST,
    // device pins
    input wire logic O_SD_CLK_EN,
    input wire logic O_SD_CKE,
    input wire logic O_SD_CS_N,
    input wire logic O_SD_RAS_N,
    input wire logic O_SD_CAS_N,
    input wire logic O_SD_WE_N,
    input wire logic [11:0] O_SD_ADDR,
    input wire logic [1:0] O_SD_BA
);
    wire logic [3:0] cmd = {O_SD_CS_N, O_SD_RAS_N, O_SD_CAS_N, O_SD_WE_N};
    wire logic mrs = cmd == sdmc_pkg::CMD_MRS;
    wire logic refr = cmd == sdmc_pkg::CMD_REF;
    wire logic quiet = cmd == sdmc_pkg::CMD_NOP || cmd == sdmc_pkg::CMD_DESEL;
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (I_RST);
    property p_mrs_low; mrs |-> O_SD_ADDR[10] == 1'b0 && O_SD_BA == 2'h0; endproperty
    a_mrs_low: assert property (p_mrs_low) else $error("mode set high bits not low");
    property p_test_mode; mrs |-> O_SD_ADDR[8:7] == sdmc_pkg::TM_NORMAL; endproperty
    a_test_mode: assert property (p_test_mode) else $error("test mode bits set");
    property p_latency; mrs |-> O_SD_ADDR[6:4] == sdmc_pkg::CL_CODE_2; endproperty
    a_latency: assert property (p_latency) else $error("wrong latency code");
    property p_mrs_gap; mrs |=> (cmd == sdmc_pkg::CMD_NOP) [*2]; endproperty
    a_mrs_gap: assert property (p_mrs_gap) else $error("command too soon after mode set");
    property p_ref_gap; refr && O_SD_CKE |=> (cmd == sdmc_pkg::CMD_NOP) [*5]; endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("refresh not followed by idle cycles");
    property p_ref_cke; refr && O_SD_CKE |-> $past(O_SD_CKE); endproperty
    a_ref_cke: assert property (p_ref_cke) else $error("refresh while powered down");
    property p_sr_hold; refr && !O_SD_CKE |=> !O_SD_CKE [*2]; endproperty
    a_sr_hold: assert property (p_sr_hold) else $error("clock enable left self refresh early");
    property p_sr_clock; $rose(O_SD_CKE) |-> $past(O_SD_CLK_EN); endproperty
    a_sr_clock: assert property (p_sr_clock) else $error("clock enable rose before clock");
    property p_sr_exit; $rose(O_SD_CKE) && !$past(O_SD_CLK_EN, 2) |-> quiet [*4]; endproperty
    a_sr_exit: assert property (p_sr_exit) else $error("command inside exit time");
    property p_pd_exit; $rose(O_SD_CKE) |-> quiet [*2]; endproperty
    a_pd_exit: assert property (p_pd_exit) else $error("command inside power-down exit");
endmodule : sdmc_ctrl_sva
bind sdmc_ctrl sdmc_ctrl_sva #(.REF_INT(REF_INT), .PD_MAX(PD_MAX)) u_sdmc_ctrl_sva (.*);

// ===== verif/sdmc_dev_model.sv
module sdmc_dev_model (
    input wire logic clk,
    input wire logic clk_en,
    input wire logic cke,
    input wire logic [3:0] cmd,
    input wire logic [11:0] addr,
    input wire logic dqm,
    output logic [11:0] mode,
    output int stop_left,
    output logic out_off,
    output int refs,
    output logic in_sr,
    output logic in_pd
);
    logic cke_q = 1'b1;
    logic [1:0] dqm_pipe = 2'h0;
    initial begin
        mode = 12'h000;
        stop_left = 0;
        out_off = 1'b0;
        refs = 0;
        in_sr = 1'b0;
        in_pd = 1'b0;
    end
    // a gated clock freezes the whole device
    always @(posedge clk) begin
        if (clk_en) begin
            cke_q <= cke;
            dqm_pipe <= {dqm_pipe[0], dqm};
            out_off <= dqm_pipe[1];
            if (cmd == sdmc_pkg::CMD_BSTOP && cke) begin
                stop_left <= (mode[6:4] == 3'h3) ? 3 : 2;
            end else if (stop_left > 0) begin
                stop_left <= stop_left - 1;
            end
            if (in_sr || in_pd) begin
                // only the clock enable is heard here
                if (cke) begin
                    in_sr <= 1'b0;
                    in_pd <= 1'b0;
                end
            end else if (cke_q && !cke && cmd != sdmc_pkg::CMD_REF) begin
                in_pd <= 1'b1;
            end else if (cke_q && !cmd[3]) begin
                if (cmd == sdmc_pkg::CMD_MRS) mode <= addr;
                if (cmd == sdmc_pkg::CMD_REF && cke) refs <= refs + 1;
                if (cmd == sdmc_pkg::CMD_REF && !cke) in_sr <= 1'b1;
            end
        end
    end
endmodule : sdmc_dev_model

// ===== verif/sdmc_ctrl_tb_top.sv
module sdmc_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RI = 50;
    logic clk, rst, mreq, bstop, sren, srex, pden, pdex, mask, busy, insr, inpd, clken, cke, cs_n, ras_n, cas_n, we_n, dqm;
    logic [11:0] mval, addr, dmode;
    logic [12:0] rtot;
    logic [1:0] ba;
    logic dsr, dpd, doff;
    int drefs, dleft, r0, n, fail_count = 0, check_count = 0, cyc = 0;
    sdmc_ctrl #(.REF_INT(RI), .PD_MAX(200)) u_sdmc_ctrl (.I_CLOCK(clk), .I_RST(rst), .i_mode_req(mreq),
        .i_mode_val(mval), .i_bstop_req(bstop), .i_sr_enter_req(sren), .i_sr_exit_req(srex), .i_pd_enter_req(pden),
        .i_pd_exit_req(pdex), .i_mask(mask), .o_busy(busy), .o_in_self_refresh(insr), .o_in_power_down(inpd),
        .o_ref_total(rtot), .O_SD_CLK_EN(clken), .O_SD_CKE(cke), .O_SD_CS_N(cs_n), .O_SD_RAS_N(ras_n),
        .O_SD_CAS_N(cas_n), .O_SD_WE_N(we_n), .O_SD_ADDR(addr), .O_SD_BA(ba), .O_SD_DQM(dqm));
    sdmc_dev_model u_sdmc_dev_model (.clk(clk), .clk_en(clken), .cke(cke), .cmd({cs_n, ras_n, cas_n, we_n}),
        .addr(addr), .dqm(dqm), .mode(dmode), .stop_left(dleft), .out_off(doff), .refs(drefs), .in_sr(dsr),
        .in_pd(dpd));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    // start each scenario just after a refresh so the next one falls due within RI cycles
    task automatic sync_ref;
        logic [12:0] t;
        t = rtot;
        for (n = 0; n < 200 && rtot === t; n++) @(negedge clk);
        for (n = 0; n < 50 && busy !== 1'b0; n++) @(negedge clk);
        check(busy, 1'b0);
    endtask : sync_ref
    task automatic t_ref;
        sync_ref();
        r0 = drefs;
        repeat (RI + 8) @(negedge clk);
        check(drefs - r0, 1);
        $display("test refresh done");
    endtask : t_ref
    task automatic t_mode;
        logic [11:0] v[5] = '{12'h000, 12'h209, 12'h7FA, 12'h80B, 12'hFFF};
        for (int i = 0; i < 5; i++) begin
            sync_ref();
            mval = v[i];
            pulse(mreq);
            check({cs_n, ras_n, cas_n, we_n}, sdmc_pkg::CMD_MRS);
            check(ba, 2'h0);
            @(negedge clk);
            check(dmode, (v[i] & 12'h20F) | 12'h020);
        end
        $display("test mode done");
    endtask : t_mode
    task automatic t_bstop;
        sync_ref();
        mask = 1'b1;
        pulse(bstop);
        check({cs_n, ras_n, cas_n, we_n}, sdmc_pkg::CMD_BSTOP);
        check(dqm, 1'b1);
        mask = 1'b0;
        @(negedge clk);
        check(dleft, 2);
        repeat (2) @(negedge clk);
        check(dleft, 0);
        check(doff, 1'b1);
        $display("test stop done");
    endtask : t_bstop
    task automatic t_pd;
        sync_ref();
        pulse(pden);
        repeat (3) @(negedge clk);
        check({dpd, inpd}, 2'h3);
        pulse(pdex);
        repeat (3) @(negedge clk);
        check(dpd, 1'b0);
        for (n = 0; n < 10 && busy !== 1'b0; n++) @(negedge clk);
        pulse(pden);
        repeat (RI + 10) @(negedge clk);
        check(dpd, 1'b0);
        $display("test power-down done");
    endtask : t_pd
    task automatic t_sr;
        sync_ref();
        r0 = drefs;
        pulse(sren);
        for (n = 0; n < 30000 && insr !== 1'b1; n++) @(negedge clk);
        repeat (2) @(negedge clk);
        check(drefs - r0, 4096);
        check({dsr, clken}, 2'h2);
        repeat (50) @(negedge clk);
        r0 = drefs;
        pulse(srex);
        for (n = 0; n < 30000 && busy !== 1'b0; n++) @(negedge clk);
        check(dsr, 1'b0);
        check(drefs - r0, 4096);
        $display("test self refresh done");
    endtask : t_sr
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        {rst, mreq, bstop, sren, srex, pden, pdex, mask} = 8'hFF & 8'h80;
        mval = 12'h000;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        check({cs_n, ras_n, cas_n, we_n, cke}, {sdmc_pkg::CMD_NOP, 1'b1});
        t_ref();
        t_mode();
        t_bstop();
        t_pd();
        t_sr();
        complete_run();
    end
endmodule : sdmc_ctrl_tb_top
